// file: design/pefm_top.sv
// The AXI4-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "pefm_params.svh"
// Function
// - exit sensor not cleared in time after registration: exit or mid jam
// - exit sensor active at switch-on raises exit-area jam
// - exit sensor active when interlock closes raises exit-area jam
// - exit sensor active in power-on or recovery raises exit-area jam
// - registration sensor too early after feed start raises feed jam
// - registration sensor too late after feed start is a misfeed jam
// - registration active at switch-on, power-on or recovery: feed jam
// - jams, cartridge or cassette missing stop motor, scanner and fuser
// - jam held until cover opened then closed again
// - cartridge switch not actuated raises cartridge-missing code
// - pause stops fuser only, held until resume command
// - empty feeder raises paper-empty, sheet completes, then stop
// - bypass tray: measured length against stored size, no stop
// - ten prints after toner-low raise replace-cartridge status
// - persistent entry shows code until fault clears
// - brief entry shows code for two seconds
// - blank entry never shows that code
// - display gating by mode table, controller and user modes
// - cover open raises cover code and stops motor, scanner and fuser
module pefm_top #(
  parameter logic [31:0] BRIEF_CYC =
    32'((`PEFM_BRIEF_MS * 64'd1000000) / `PEFM_CLK_PERIOD_NS),
  parameter logic [31:0] EXIT_CYC  =
    32'((`PEFM_EXIT_MS * 64'd1000000) / `PEFM_CLK_PERIOD_NS),
  parameter logic [31:0] FEED_CYC  =
    32'((`PEFM_FEED_MS * 64'd1000000) / `PEFM_CLK_PERIOD_NS),
  parameter logic [31:0] EARLY_CYC =
    32'((`PEFM_EARLY_MS * 64'd1000000 + `PEFM_CLK_PERIOD_NS - 64'd1)
        / `PEFM_CLK_PERIOD_NS)
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        ce,
  input  wire logic [10:0] sensor_pins,
  input  wire logic        memory_error,
  input  wire logic        scanner_fault,
  input  wire logic        fuser_fault,
  output logic             main_motor_off,
  output logic             scanner_laser_unit_off,
  output logic             fuser_off,
  output logic             feed_stop,
  output logic             display_on,
  output logic [3:0]       display_code,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  // the early limit must sit inside the feed window
  if (EARLY_CYC == 32'h0 || EARLY_CYC >= FEED_CYC || BRIEF_CYC == 32'h0 ||
      EXIT_CYC == 32'h0) begin : g_bad_timing
    $error("pefm_top: timing parameters out of range");
  end

  // ************************************************************
  // helpers
  // ************************************************************
  // {persist, brief} masks, bit i is code index i
  function automatic logic [25:0] disp_masks(input logic [3:0] m);
    logic [25:0] r;
    r = 26'h0;
    unique case (m)
      pefm_pkg::MODE_CONTROLLER:  r = {13'h11FF, 13'h0000};
      pefm_pkg::MODE_USER:        r = {13'h0009, 13'h0000};
      pefm_pkg::MODE_DIAG_IDLE,
      pefm_pkg::MODE_DIAG_COUNT,
      pefm_pkg::MODE_DIAG_OUTPUT: r = {13'h0008, 13'h0000};
      pefm_pkg::MODE_DIAG_INPUT:  r = {13'h0000, 13'h0000};
      pefm_pkg::MODE_CFG_SELECT:  r = {13'h0008, 13'h0686};
      pefm_pkg::MODE_CFG_PARAM:   r = {13'h0005, 13'h0000};
      pefm_pkg::MODE_CFG_TEST:    r = {13'h1EFF, 13'h0000};
      default:                    r = 26'h0;
    endcase
    return r;
  endfunction : disp_masks

  function automatic logic [31:0] strb_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) r[i*8 +: 8] = wd[i*8 +: 8];
    end
    return r;
  endfunction : strb_merge

  // ************************************************************
  // state
  // ************************************************************
  pefm_pkg::pefm_state_t s_q;
  pefm_pkg::pefm_state_t s_d;

  logic [10:0] rise;
  logic [10:0] fall;
  logic [12:0] jam_mask;
  logic [12:0] shut_mask;
  logic [25:0] masks;
  logic [12:0] shown;
  logic [3:0]  sel;
  logic        sel_ok;
  logic [31:0] diff;
  logic [31:0] rd_word;
  logic        rd_hit;
  logic        wr_hit;

  assign jam_mask  = 13'h0070;
  // jams, cart, cassette, cover, memory, scanner
  assign shut_mask = 13'h02FB;

  always_comb begin
    s_d     = s_q;
    // no edges until the third stage holds real pin levels
    rise    = (s_q.boot == `PEFM_BOOT_CYC) ? s_q.sync2 & ~s_q.sync3 : 11'h0;
    fall    = (s_q.boot == `PEFM_BOOT_CYC) ? ~s_q.sync2 & s_q.sync3 : 11'h0;
    masks   = disp_masks(s_q.mode);
    shown   = 13'h0;
    sel     = 4'h0;
    sel_ok  = 1'b0;
    diff    = 32'h0;
    rd_word = 32'h0;
    rd_hit  = 1'b1;
    wr_hit  = 1'b1;
    if (ce) begin
      // ************************************************************
      // pin synchronisers and boot window
      // ************************************************************
      s_d.sync1 = sensor_pins;
      s_d.sync2 = s_q.sync1;
      s_d.sync3 = s_q.sync2;
      if (s_q.boot != `PEFM_BOOT_CYC) s_d.boot = s_q.boot + 2'h1;

      // ************************************************************
      // jam clearing first, so that new events win
      // ************************************************************
      if (|(s_q.flags & jam_mask)) begin
        if (!s_q.sync2[`PEFM_PIN_ILOCK]) s_d.cover_opened = 1'b1;
        else if (s_q.cover_opened) begin
          s_d.flags        = s_q.flags & ~jam_mask;
          s_d.cover_opened = 1'b0;
        end
      end

      // ************************************************************
      // paper path timers
      // ************************************************************
      if (s_q.feed_act) s_d.feed_cnt = s_q.feed_cnt + 32'h1;
      if (s_q.exit_act) s_d.exit_cnt = s_q.exit_cnt + 32'h1;
      if (s_q.sync2[`PEFM_PIN_EXIT]) s_d.exit_seen = 1'b1;
      if (s_q.feed_act && s_q.feed_cnt >= FEED_CYC) begin
        s_d.flags[pefm_pkg::FEED_AREA_JAM] = 1'b1;
        s_d.feed_act = 1'b0;
      end
      if (s_q.exit_act && s_q.exit_seen && fall[`PEFM_PIN_EXIT])
        s_d.exit_act = 1'b0;
      else if (s_q.exit_act && s_q.exit_cnt >= EXIT_CYC) begin
        // exit seen but not cleared: exit jam; never reached the exit sensor: stuck between the two
        if (s_q.exit_seen) s_d.flags[pefm_pkg::EXIT_AREA_JAM] = 1'b1;
        else s_d.flags[pefm_pkg::MID_PATH_JAM] = 1'b1;
        s_d.exit_act = 1'b0;
      end
      if (rise[`PEFM_PIN_REG] && s_q.feed_act) begin
        if (s_q.feed_cnt < EARLY_CYC)
          s_d.flags[pefm_pkg::FEED_AREA_JAM] = 1'b1;
        s_d.feed_act  = 1'b0;
        s_d.exit_act  = 1'b1;
        s_d.exit_cnt  = 32'h0;
        s_d.exit_seen = 1'b0;
      end
      if (rise[`PEFM_PIN_FEED]) begin
        s_d.feed_act = 1'b1;
        s_d.feed_cnt = 32'h0;
      end

      // ************************************************************
      // sheet length on the bypass tray
      // ************************************************************
      if (rise[`PEFM_PIN_REG]) s_d.len_cnt = 32'h0;
      else if (s_q.sync2[`PEFM_PIN_REG]) s_d.len_cnt = s_q.len_cnt + 32'h1;
      if (fall[`PEFM_PIN_REG]) begin
        s_d.len_last = s_q.len_cnt;
        diff = (s_q.len_cnt > s_q.size_ref) ? s_q.len_cnt - s_q.size_ref
                                            : s_q.size_ref - s_q.len_cnt;
        if (s_q.bypass_en)
          s_d.flags[pefm_pkg::SIZE_MISMATCH] = (diff > `PEFM_SIZE_TOL);
      end
      if (!s_q.bypass_en) s_d.flags[pefm_pkg::SIZE_MISMATCH] = 1'b0;

      // ************************************************************
      // presence checks, switch-on and sequence checks
      // ************************************************************
      if (s_q.boot == `PEFM_BOOT_CYC) begin
        if (s_q.sync2[`PEFM_PIN_EXIT] &&
            (s_q.boot != s_d.boot || rise[`PEFM_PIN_ILOCK] ||
             s_q.sync2[`PEFM_PIN_PWRSEQ] || s_q.sync2[`PEFM_PIN_RECOV]))
          s_d.flags[pefm_pkg::EXIT_AREA_JAM] = 1'b1;
        if (s_q.sync2[`PEFM_PIN_REG] &&
            (s_q.sync2[`PEFM_PIN_PWRSEQ] || s_q.sync2[`PEFM_PIN_RECOV]))
          s_d.flags[pefm_pkg::FEED_AREA_JAM] = 1'b1;
        s_d.flags[pefm_pkg::COVER_OPEN_CODE] =
          !s_q.sync2[`PEFM_PIN_ILOCK];
        s_d.flags[pefm_pkg::CARTRIDGE_MISSING] =
          !s_q.sync2[`PEFM_PIN_CART];
        s_d.flags[pefm_pkg::CASSETTE_MISSING] = !s_q.sync2[`PEFM_PIN_CASS];
        s_d.flags[pefm_pkg::PAPER_EMPTY] =
          s_q.sync2[`PEFM_PIN_EMPTY];
      end
      // first look at settled pins counts as switch-on
      if (s_q.boot == 2'h2 && s_d.boot == `PEFM_BOOT_CYC) begin
        if (s_q.sync2[`PEFM_PIN_EXIT])
          s_d.flags[pefm_pkg::EXIT_AREA_JAM] = 1'b1;
        if (s_q.sync2[`PEFM_PIN_REG])
          s_d.flags[pefm_pkg::FEED_AREA_JAM] = 1'b1;
      end
      if (memory_error)  s_d.flags[pefm_pkg::MEMORY_ERROR_CODE]  = 1'b1;
      if (scanner_fault) s_d.flags[pefm_pkg::SCANNER_FAULT_CODE] = 1'b1;
      if (fuser_fault)   s_d.flags[pefm_pkg::FUSER_FAULT_CODE]   = 1'b1;

      // ************************************************************
      // toner countdown
      // ************************************************************
      if (!s_q.sync2[`PEFM_PIN_CART]) begin
        s_d.toner_arm = 1'b0;
        s_d.toner_cnt = 4'h0;
      end else begin
        if (rise[`PEFM_PIN_TONER]) s_d.toner_arm = 1'b1;
        if (s_q.toner_arm && rise[`PEFM_PIN_DONE] &&
            s_q.toner_cnt != `PEFM_TONER_PRINTS)
          s_d.toner_cnt = s_q.toner_cnt + 4'h1;
      end
      s_d.flags[pefm_pkg::REPLACE_CARTRIDGE] =
        (s_d.toner_cnt == `PEFM_TONER_PRINTS);

      // ************************************************************
      // register bus
      // ************************************************************
      if (s_axi_awvalid && s_q.awready) begin
        s_d.aw_got  = 1'b1;
        s_d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_q.wready) begin
        s_d.w_got = 1'b1;
        s_d.wdata = s_axi_wdata;
        s_d.wstrb = s_axi_wstrb;
      end
      if (s_q.bvalid && s_axi_bready) s_d.bvalid = 1'b0;
      if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
        unique case (s_q.aw_addr)
          `PEFM_OFF_CTRL: begin
            if (s_q.wstrb[0]) begin
              s_d.mode      = s_q.wdata[`PEFM_CTRL_MODE_LSB +: 4];
              s_d.bypass_en = s_q.wdata[`PEFM_CTRL_BYPASS_BIT];
            end
          end
          `PEFM_OFF_CMD: begin
            if (s_q.wstrb[0] && s_q.wdata[`PEFM_CMD_RESUME_BIT])
              s_d.pause = 1'b0;
            if (s_q.wstrb[0] && s_q.wdata[`PEFM_CMD_PAUSE_BIT])
              s_d.pause = 1'b1;
          end
          `PEFM_OFF_SIZE:
            s_d.size_ref = strb_merge(s_q.size_ref, s_q.wdata, s_q.wstrb);
          default: wr_hit = 1'b0;
        endcase
        s_d.bresp  = wr_hit ? 2'b00 : 2'b10;
        s_d.bvalid = 1'b1;
        s_d.aw_got = 1'b0;
        s_d.w_got  = 1'b0;
      end
      s_d.flags[pefm_pkg::FUSER_PAUSE] = s_d.pause;
      s_d.awready = !s_d.aw_got && !s_d.bvalid;
      s_d.wready  = !s_d.w_got && !s_d.bvalid;

      if (s_q.rvalid && s_axi_rready) s_d.rvalid = 1'b0;
      if (s_axi_arvalid && s_q.arready) begin
        unique case (s_axi_araddr)
          `PEFM_OFF_CTRL:    rd_word = {27'h0, s_q.bypass_en, s_q.mode};
          `PEFM_OFF_CMD:     rd_word = 32'h0;
          `PEFM_OFF_SIZE:    rd_word = s_q.size_ref;
          `PEFM_OFF_STATUS:  rd_word = {10'h0, s_q.disp_on, 1'b0,
                                        s_q.disp_code, 3'h0, s_q.flags};
          `PEFM_OFF_MEASURE: rd_word = s_q.len_last;
          default:           rd_hit  = 1'b0;
        endcase
        s_d.rdata  = rd_word;
        s_d.rresp  = rd_hit ? 2'b00 : 2'b10;
        s_d.rvalid = 1'b1;
      end
      s_d.arready = !s_d.rvalid;

      // ************************************************************
      // actuators: outputs follow next flags directly
      // ************************************************************
      s_d.motor_off   = |(s_d.flags & shut_mask);
      s_d.scanner_off = |(s_d.flags & shut_mask);
      s_d.fuser_off   = |(s_d.flags & shut_mask) || s_d.pause ||
                        s_d.flags[pefm_pkg::FUSER_FAULT_CODE];
      // a sheet already in the path is allowed to finish
      s_d.paper_stop  = s_d.flags[pefm_pkg::PAPER_EMPTY] &&
                        !s_d.feed_act && !s_d.exit_act;

      // ************************************************************
      // display selection
      // ************************************************************
      // a mode written this cycle already gates the display
      masks = disp_masks(s_d.mode);
      shown = s_q.flags & (masks[25:13] | masks[12:0]);
      for (int i = 12; i >= 0; i--) begin
        if (shown[i]) begin
          sel    = 4'(i);
          sel_ok = 1'b1;
        end
      end
      if (!sel_ok) begin
        s_d.disp_on  = 1'b0;
        s_d.last_sel = 4'hF;
      end else if (masks[sel]) begin
        if (sel != s_q.last_sel) s_d.brief_cnt = BRIEF_CYC - 32'h1;
        else if (s_q.brief_cnt != 32'h0)
          s_d.brief_cnt = s_q.brief_cnt - 32'h1;
        s_d.disp_on   = (sel != s_q.last_sel) || (s_q.brief_cnt != 32'h0);
        s_d.last_sel  = sel;
        s_d.disp_code = sel;
      end else begin
        s_d.disp_on   = 1'b1;
        s_d.last_sel  = sel;
        s_d.disp_code = sel;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_q             <= '0;
      s_q.mode        <= `PEFM_RST_MODE;
      s_q.size_ref    <= `PEFM_RST_SIZE;
      s_q.motor_off   <= `PEFM_RST_SHUT;
      s_q.scanner_off <= `PEFM_RST_SHUT;
      s_q.fuser_off   <= `PEFM_RST_SHUT;
      s_q.last_sel    <= 4'hF;
    end else begin
      s_q <= s_d;
    end
  end

  assign main_motor_off         = s_q.motor_off;
  assign scanner_laser_unit_off = s_q.scanner_off;
  assign fuser_off              = s_q.fuser_off;
  assign feed_stop              = s_q.paper_stop;
  assign display_on             = s_q.disp_on;
  assign display_code           = s_q.disp_code;
  assign s_axi_awready          = s_q.awready;
  assign s_axi_wready           = s_q.wready;
  assign s_axi_bvalid           = s_q.bvalid;
  assign s_axi_bresp            = s_q.bresp;
  assign s_axi_arready          = s_q.arready;
  assign s_axi_rvalid           = s_q.rvalid;
  assign s_axi_rdata            = s_q.rdata;
  assign s_axi_rresp            = s_q.rresp;

  // ************************************************************
  // assertions
  // ************************************************************
  property p_shutdown;
    @(posedge clk) disable iff (!reset_n)
      |(s_q.flags & shut_mask) |-> main_motor_off && scanner_laser_unit_off
                                   && fuser_off;
  endproperty
  a_shutdown: assert property (p_shutdown)
    else $error("shutdown fault without actuator stop");

  property p_cart;
    @(posedge clk) disable iff (!reset_n)
      ce && s_q.boot == 2'h3 && !s_q.sync2[3]
        |=> s_q.flags[7] && main_motor_off;
  endproperty
  a_cart: assert property (p_cart)
    else $error("cartridge missing not flagged");

  property p_jam_hold;
    @(posedge clk) disable iff (!reset_n)
      s_q.flags[4] && !s_q.cover_opened |=> s_q.flags[4];
  endproperty
  a_jam_hold: assert property (p_jam_hold)
    else $error("jam dropped without cover cycle");

  property p_feed_late;
    @(posedge clk) disable iff (!reset_n)
      ce && s_q.feed_act && s_q.feed_cnt >= FEED_CYC
        && !rise[`PEFM_PIN_FEED] |=> s_q.flags[6] && !s_q.feed_act;
  endproperty
  a_feed_late: assert property (p_feed_late)
    else $error("misfeed not flagged");

  property p_early;
    @(posedge clk) disable iff (!reset_n)
      ce && s_q.feed_act && rise[`PEFM_PIN_REG] && s_q.feed_cnt < EARLY_CYC
        |=> s_q.flags[6] && main_motor_off;
  endproperty
  a_early: assert property (p_early)
    else $error("early registration not flagged");

  property p_pause;
    @(posedge clk) disable iff (!reset_n)
      s_q.pause |-> fuser_off && s_q.flags[8];
  endproperty
  a_pause: assert property (p_pause)
    else $error("pause without fuser stop");

  property p_user_gate;
    @(posedge clk) disable iff (!reset_n)
      display_on && s_q.mode == 4'h1 |-> display_code == 4'h0
                                         || display_code == 4'h3;
  endproperty
  a_user_gate: assert property (p_user_gate)
    else $error("user mode shows a gated code");

  property p_toner;
    @(posedge clk) disable iff (!reset_n)
      $rose(s_q.flags[12]) |-> s_q.toner_cnt == 4'hA && s_q.toner_arm;
  endproperty
  a_toner: assert property (p_toner)
    else $error("replace status before ten prints");

  property p_blank;
    @(posedge clk) disable iff (!reset_n)
      s_q.mode == 4'h4 |-> !display_on;
  endproperty
  a_blank: assert property (p_blank)
    else $error("input test mode shows a code");

  c_jam_clear: cover property (@(posedge clk) disable iff (!reset_n)
    s_q.flags[4] ##1 !s_q.flags[4]);
  c_brief: cover property (@(posedge clk) disable iff (!reset_n)
    display_on && s_q.mode == 4'h6 ##1 !display_on);
  c_replace: cover property (@(posedge clk) disable iff (!reset_n)
    $rose(s_q.flags[12]));
endmodule : pefm_top
`default_nettype wire

// file: include/pefm_params.svh
`ifndef PEFM_PARAMS_SVH
`define PEFM_PARAMS_SVH
// ************************************************************
// register offsets (byte addresses)
// ************************************************************
`define PEFM_OFF_CTRL     8'h00
`define PEFM_OFF_CMD      8'h04
`define PEFM_OFF_SIZE     8'h08
`define PEFM_OFF_STATUS   8'h0C
`define PEFM_OFF_MEASURE  8'h10
// ************************************************************
// field positions
// ************************************************************
`define PEFM_CTRL_MODE_LSB  0
`define PEFM_CTRL_BYPASS_BIT 4
`define PEFM_CMD_PAUSE_BIT  0
`define PEFM_CMD_RESUME_BIT 1
`define PEFM_STAT_CODE_LSB  16
`define PEFM_STAT_DISP_BIT  21
// pin vector positions
`define PEFM_PIN_REG      0
`define PEFM_PIN_EXIT     1
`define PEFM_PIN_EMPTY    2
`define PEFM_PIN_CART     3
`define PEFM_PIN_TONER    4
`define PEFM_PIN_ILOCK    5
`define PEFM_PIN_CASS     6
`define PEFM_PIN_FEED     7
`define PEFM_PIN_DONE     8
`define PEFM_PIN_PWRSEQ   9
`define PEFM_PIN_RECOV    10
// ************************************************************
// reset values
// ************************************************************
`define PEFM_RST_MODE     4'h0
`define PEFM_RST_SIZE     32'h0000_0000
`define PEFM_RST_SHUT     1'b1
// ************************************************************
// timing
// ************************************************************
`define PEFM_CLK_PERIOD_NS 64'd10
`define PEFM_BRIEF_MS      64'd2000
`define PEFM_EXIT_MS       64'd3000
`define PEFM_FEED_MS       64'd2000
`define PEFM_EARLY_MS      64'd100
`define PEFM_SIZE_TOL      32'h0000_1000
`define PEFM_TONER_PRINTS  4'hA
`define PEFM_BOOT_CYC      2'h3
`endif

// file: include/pefm_pkg.sv
package pefm_pkg;
  typedef enum logic [3:0] {
    MODE_CONTROLLER  = 4'h0, MODE_USER        = 4'h1,
    MODE_DIAG_IDLE   = 4'h2, MODE_DIAG_COUNT  = 4'h3,
    MODE_DIAG_INPUT  = 4'h4, MODE_DIAG_OUTPUT = 4'h5,
    MODE_CFG_SELECT  = 4'h6, MODE_CFG_PARAM   = 4'h7,
    MODE_CFG_TEST    = 4'h8
  } pefm_mode_t;
  // index order is also display priority: lower index wins
  typedef enum logic [3:0] {
    MEMORY_ERROR_CODE = 4'h0, SCANNER_FAULT_CODE    = 4'h1,
    FUSER_FAULT_CODE  = 4'h2, COVER_OPEN_CODE       = 4'h3,
    EXIT_AREA_JAM     = 4'h4, MID_PATH_JAM          = 4'h5,
    FEED_AREA_JAM     = 4'h6, CARTRIDGE_MISSING     = 4'h7,
    FUSER_PAUSE       = 4'h8, CASSETTE_MISSING      = 4'h9,
    PAPER_EMPTY       = 4'hA, SIZE_MISMATCH         = 4'hB,
    REPLACE_CARTRIDGE = 4'hC
  } pefm_code_t;
  typedef struct packed {
    logic [10:0] sync1;
    logic [10:0] sync2;
    logic [10:0] sync3;
    logic [12:0] flags;
    logic        feed_act;
    logic [31:0] feed_cnt;
    logic        exit_act;
    logic        exit_seen;
    logic [31:0] exit_cnt;
    logic [31:0] len_cnt;
    logic [31:0] len_last;
    logic        cover_opened;
    logic [1:0]  boot;
    logic [3:0]  toner_cnt;
    logic        toner_arm;
    logic        pause;
    logic        paper_stop;
    logic        motor_off;
    logic        scanner_off;
    logic        fuser_off;
    logic        disp_on;
    logic [3:0]  disp_code;
    logic [3:0]  last_sel;
    logic [31:0] brief_cnt;
    logic [3:0]  mode;
    logic        bypass_en;
    logic [31:0] size_ref;
    logic        aw_got;
    logic [7:0]  aw_addr;
    logic        w_got;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } pefm_state_t;
endpackage : pefm_pkg

// file: tb/pefm_path_model.sv
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// paper path sensors
// ************************************************************
module pefm_path_model (
  input  wire logic   clk,
  output logic [10:0] sensor_pins
);
  // cartridge in, cover closed, cassette in, sheet left at exit
  initial sensor_pins = 11'h06A;
  task automatic set(input int b, input logic v);
    @(posedge clk);
    sensor_pins[b] <= v;
  endtask : set
endmodule : pefm_path_model
`default_nettype wire

// file: tb/pefm_top_test.sv
`timescale 1ns/10ps
`default_nettype none
module pefm_top_test;
  logic clk, reset_n, ce, memory_error, scanner_fault, fuser_fault;
  wire logic [10:0] sensor_pins;
  logic main_motor_off, scanner_laser_unit_off, fuser_off, feed_stop;
  logic display_on, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0] display_code, s_axi_wstrb;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  int err_total, num_checks;
  // short limits keep the run brief
  pefm_top #(.BRIEF_CYC(32'h32), .EXIT_CYC(32'h28), .FEED_CYC(32'h1E),
    .EARLY_CYC(32'h5)) dut (.*);
  pefm_path_model path (.clk(clk), .sensor_pins(sensor_pins));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic ok);
    num_checks++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("[ERR] %0t unexpected output", $time);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    fork
      begin
        do @(posedge clk); while (!s_axi_awready);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge clk); while (!s_axi_wready);
        s_axi_wvalid <= 1'b0;
      end
    join
    s_axi_bready <= 1'b1;
    do @(posedge clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd_reg(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd_reg
  task automatic cover_cycle;
    path.set(5, 1'b0);
    wt(6);
    chk(display_code === 4'h3 && main_motor_off === 1'b1);
    path.set(5, 1'b1);
    wt(6);
  endtask : cover_cycle
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  initial begin
    {reset_n, memory_error, scanner_fault, fuser_fault} = 4'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, ce} = 3'h1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    wt(2);
    reset_n <= 1'b1;
    wt(8);
    chk(display_on === 1'b1 && display_code === 4'h4);
    chk({main_motor_off, scanner_laser_unit_off, fuser_off} === 3'h7);
    path.set(1, 1'b0);
    wt(6);
    chk(display_code === 4'h4);
    cover_cycle;
    chk(display_on === 1'b0 && main_motor_off === 1'b0);
    $display("boot jam test done");
    wr(8'h04, 32'h1);
    wt(12);
    chk(fuser_off === 1'b1 && main_motor_off === 1'b0);
    chk(display_code === 4'h8);
    wr(8'h04, 32'h2);
    wt(4);
    chk(fuser_off === 1'b0 && display_on === 1'b0);
    $display("pause test done");
    path.set(7, 1'b1);
    path.set(0, 1'b1);
    wt(6);
    chk(display_code === 4'h6 && fuser_off === 1'b1);
    path.set(1, 1'b1);
    path.set(0, 1'b0);
    path.set(1, 1'b0);
    path.set(7, 1'b0);
    cover_cycle;
    chk(display_on === 1'b0);
    $display("early arrival test done");
    path.set(3, 1'b0);
    wt(6);
    chk(display_code === 4'h7 && main_motor_off === 1'b1);
    wr(8'h00, 32'h1);
    wt(3);
    chk(display_on === 1'b0);
    rd_reg(8'h00);
    chk(rd[3:0] === 4'h1);
    rd_reg(8'h20);
    chk(rr === 2'b10);
    wr(8'h00, 32'h6);
    wt(3);
    chk(display_on === 1'b1 && display_code === 4'h7);
    wt(55);
    chk(display_on === 1'b0);
    wr(8'h00, 32'h0);
    wt(3);
    chk(display_on === 1'b1 && display_code === 4'h7);
    wr(8'h00, 32'h4);
    wt(3);
    chk(display_on === 1'b0);
    wr(8'h00, 32'h0);
    path.set(3, 1'b1);
    wt(6);
    chk(display_on === 1'b0 && main_motor_off === 1'b0);
    $display("cartridge and mode test done");
    path.set(2, 1'b1);
    wt(6);
    chk(feed_stop === 1'b1 && display_on === 1'b0);
    path.set(2, 1'b0);
    wt(6);
    chk(feed_stop === 1'b0);
    $display("paper empty test done");
    path.set(4, 1'b1);
    repeat (9) begin
      path.set(8, 1'b1);
      path.set(8, 1'b0);
    end
    wt(6);
    chk(display_on === 1'b0);
    path.set(8, 1'b1);
    path.set(8, 1'b0);
    wt(6);
    chk(display_on === 1'b1 && display_code === 4'hC);
    path.set(4, 1'b0);
    $display("toner test done");
    path.set(7, 1'b1);
    wt(10);
    path.set(0, 1'b1);
    path.set(0, 1'b0);
    path.set(7, 1'b0);
    wt(45);
    chk(display_code === 4'h5 && main_motor_off === 1'b1);
    cover_cycle;
    $display("mid path jam test done");
    // misfeed last: no sheet ever closes this feed timer
    path.set(7, 1'b1);
    wt(40);
    chk(display_code === 4'h6 && main_motor_off === 1'b1);
    $display("misfeed test done");
    end_sim;
  end
  initial begin
    wt(3000);
    err_total++;
    end_sim;
  end
endmodule : pefm_top_test
`default_nettype wire
